// ==== core/rps_sequencer.sv ====
/*
 * Receiver power-state sequencer: reset, hibernate and full-on control,
 * toggle pulse qualification, pin hold and patch reload requests.
 * Assumes power_toggle and ext_reset_n are asynchronous pins; the
 * eeprom reader and patch source live outside and answer reload_req.
 */
`include "rps_map.svh"
`default_nettype none
module rps_sequencer #(
    parameter int PATCH_BYTES = `RPS_PATCH_MAX_BYTES,
    parameter int NPINS = 16
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic power_toggle,
    input wire logic ext_reset_n,
    input wire logic rtc_running,
    input wire logic eeprom_present,
    input wire rps_pkg::rps_patch_wr_s patch_wr,
    input wire logic reload_done,
    input wire logic [NPINS-1:0] pins_func,
    output logic [NPINS-1:0] pins_out,
    output logic serial_oe_n,
    output rps_pkg::rps_state_e state,
    output rps_pkg::rps_power_s power,
    output logic wakeup,
    output logic data_ram_clear,
    output logic reload_req,
    output logic aiding_valid,
    output logic orbit_store_en,
    output logic patch_valid,
    output logic [7:0] patch_rd_data,
    input wire logic [14:0] patch_rd_addr
);
    localparam int MINC = `RPS_TOGGLE_MIN_CYC;

    rps_pkg::rps_state_e state_q, state_d;
    logic [2:0] tog_sync_q, rst_sync_q;
    logic [`RPS_PULSE_CW-1:0] hi_cnt_q;
    logic toggle_ok;
    logic force_rst;
    logic after_reset_q;
    logic patch_valid_q;
    logic aiding_q;
    logic [NPINS-1:0] pins_q;
    logic [7:0] rd_q;
    logic [7:0] patch_mem [PATCH_BYTES];

    // Three stage synchronisers; only stages 2 and 3 are compared
    always_ff @(posedge mclk) begin
        if (rst) begin
            tog_sync_q <= 3'h0;
            rst_sync_q <= 3'h7;
        end else begin
            tog_sync_q <= {tog_sync_q[1:0], power_toggle};
            rst_sync_q <= {rst_sync_q[1:0], ext_reset_n};
        end
    end

    // Forced reset once the synchronised reset pin agrees low
    assign force_rst = ~rst_sync_q[1] & ~rst_sync_q[2];

    // High phase width counter, saturating; it holds while the stages
    // disagree so the width survives until the fall is confirmed
    always_ff @(posedge mclk) begin
        if (rst || force_rst) begin
            hi_cnt_q <= '0;
        end else if (tog_sync_q[1] & tog_sync_q[2]) begin
            if (hi_cnt_q != {`RPS_PULSE_CW{1'b1}}) begin
                hi_cnt_q <= hi_cnt_q + 1'b1;
            end
        end else if (~tog_sync_q[1] & ~tog_sync_q[2]) begin
            hi_cnt_q <= '0;
        end
    end

    // Falling edge ends the pulse; short pulses count as glitches
    assign toggle_ok = ~tog_sync_q[1] & ~tog_sync_q[2] & (hi_cnt_q > MINC);

    // Next state
    always_comb begin
        state_d = state_q;
        unique case (state_q)
            rps_pkg::RPS_RESET: begin
                if (rtc_running) state_d = rps_pkg::RPS_HIBER;
            end
            rps_pkg::RPS_HIBER: begin
                if (toggle_ok) state_d = rps_pkg::RPS_FULL;
            end
            rps_pkg::RPS_FULL: begin
                if (toggle_ok) state_d = rps_pkg::RPS_HIBER;
            end
            default: state_d = rps_pkg::RPS_RESET;
        endcase
        if (force_rst) state_d = rps_pkg::RPS_RESET;
    end

    always_ff @(posedge mclk) begin
        if (rst) state_q <= rps_pkg::RPS_RESET;
        else state_q <= state_d;
    end

    // Domain power: baseband and RF only in full on
    always_comb begin
        power.keep_alive = 1'b1;
        power.rtc = 1'b1;
        power.patch_ram = 1'b1;
        power.backup_ram = 1'b1;
        power.baseband = (state_q == rps_pkg::RPS_FULL);
        power.rf = (state_q == rps_pkg::RPS_FULL);
    end

    // Track whether the next wake follows a reset
    always_ff @(posedge mclk) begin
        if (rst || state_q == rps_pkg::RPS_RESET) begin
            after_reset_q <= 1'b1;
        end else if (state_q == rps_pkg::RPS_HIBER &&
                     state_d == rps_pkg::RPS_FULL) begin
            after_reset_q <= 1'b0;
        end
    end

    // Patch RAM: invalid after reset or power-up, valid once reloaded
    always_ff @(posedge mclk) begin
        if (rst || state_q == rps_pkg::RPS_RESET) begin
            patch_valid_q <= 1'b0;
        end else if (reload_done) begin
            patch_valid_q <= 1'b1;
        end
    end

    // Byte store sized for the largest patch image
    always_ff @(posedge mclk) begin
        if (patch_wr.valid && int'(patch_wr.addr) < PATCH_BYTES) begin
            patch_mem[patch_wr.addr] <= patch_wr.data;
        end
        rd_q <= patch_mem[patch_rd_addr];
    end

    // Reload request held until the reader reports done; a new request
    // wins over a done in the same cycle so no reload is lost
    always_ff @(posedge mclk) begin
        if (rst || force_rst) begin
            reload_req <= 1'b0;
        end else if (eeprom_present && after_reset_q &&
                     state_q == rps_pkg::RPS_HIBER &&
                     state_d == rps_pkg::RPS_FULL) begin
            reload_req <= 1'b1;
        end else if (reload_done) begin
            reload_req <= 1'b0;
        end
    end

    // Aiding data lives in backup RAM, so the reset pin leaves it valid; rst clears it outside full on
    always_ff @(posedge mclk) begin
        if (state_q == rps_pkg::RPS_FULL) aiding_q <= 1'b1;
        else if (rst) aiding_q <= 1'b0;
    end

    // Pin hold: capture while running, freeze during hibernate
    always_ff @(posedge mclk) begin
        if (rst || state_q == rps_pkg::RPS_RESET) begin
            pins_q <= NPINS'(`RPS_PINS_RESET);
        end else if (state_q == rps_pkg::RPS_FULL) begin
            pins_q <= pins_func;
        end
    end

    // Outputs
    assign state = state_q;
    assign pins_out = pins_q;
    assign serial_oe_n = (state_q != rps_pkg::RPS_FULL);
    assign wakeup = (state_q == rps_pkg::RPS_FULL);
    assign data_ram_clear = (state_q == rps_pkg::RPS_RESET);
    assign aiding_valid = aiding_q;
    assign orbit_store_en = eeprom_present;
    assign patch_valid = patch_valid_q;
    assign patch_rd_data = rd_q;

    a_short_pulse: assert property (@(posedge mclk) disable iff (rst)
        (state_q == rps_pkg::RPS_HIBER && !toggle_ok && !force_rst)
        |=> state_q == rps_pkg::RPS_HIBER)
        else $error("hibernate left without valid toggle");
    a_toggle_flip: assert property (@(posedge mclk) disable iff (rst)
        (toggle_ok && !force_rst && state_q == rps_pkg::RPS_FULL)
        |=> state_q == rps_pkg::RPS_HIBER)
        else $error("full on did not enter hibernate");
    a_ext_reset: assert property (@(posedge mclk) disable iff (rst)
        force_rst |=> state_q == rps_pkg::RPS_RESET)
        else $error("external reset ignored");
    a_hiber_power: assert property (@(posedge mclk) disable iff (rst)
        state_q == rps_pkg::RPS_HIBER |-> !power.baseband && !power.rf)
        else $error("baseband powered in hibernate");
    a_boot_hiber: assert property (@(posedge mclk) disable iff (rst)
        (state_q == rps_pkg::RPS_RESET && rtc_running && !force_rst)
        |=> state_q == rps_pkg::RPS_HIBER)
        else $error("reset not released to hibernate");
    a_pin_hold: assert property (@(posedge mclk) disable iff (rst)
        (state_q == rps_pkg::RPS_HIBER && $past(state_q) ==
         rps_pkg::RPS_HIBER) |-> $stable(pins_out) && serial_oe_n)
        else $error("pins moved in hibernate");
    a_patch_clear: assert property (@(posedge mclk) disable iff (rst)
        state_q == rps_pkg::RPS_RESET |=> !patch_valid)
        else $error("patch valid after reset");
    a_reload_req: assert property (@(posedge mclk) disable iff (rst)
        (eeprom_present && after_reset_q && !force_rst && !reload_done &&
         state_q == rps_pkg::RPS_HIBER && toggle_ok) |=> reload_req)
        else $error("patch reload not requested");
endmodule : rps_sequencer
`default_nettype wire

// ==== core/rps_map.svh ====
/*
 * Constants for the receiver power-state sequencer: timing counts,
 * patch sizes and reset values.
 * Assumes a 20 MHz system clock; included by the design.
 */
`ifndef RPS_MAP_SVH
`define RPS_MAP_SVH

`define RPS_CLK_HZ 20000000
`define RPS_TOGGLE_MIN_NS 90000
// Least high time rounds up to whole cycles
`define RPS_TOGGLE_MIN_CYC \
    ((`RPS_TOGGLE_MIN_NS * (`RPS_CLK_HZ / 1000000) + 999) / 1000)
`define RPS_PATCH_MAX_BYTES 24576
`define RPS_PATCH_AW 15
`define RPS_PULSE_CW 12
`define RPS_PINS_RESET 16'h0000

`endif

// ==== core/rps_pkg.sv ====
/*
 * Types for the receiver power-state sequencer.
 * Assumes rps_map.svh is on the include path.
 */
`default_nettype none
package rps_pkg;
    // Power states, Gray coded along reset -> hibernate -> full on
    typedef enum logic [1:0] {
        RPS_RESET = 2'b00,
        RPS_HIBER = 2'b01,
        RPS_FULL  = 2'b11
    } rps_state_e;

    // Power domain enables
    typedef struct packed {
        logic keep_alive;
        logic rtc;
        logic patch_ram;
        logic backup_ram;
        logic baseband;
        logic rf;
    } rps_power_s;

    // Patch byte write from the eeprom reader or the host
    typedef struct packed {
        logic        valid;
        logic [14:0] addr;
        logic [7:0]  data;
    } rps_patch_wr_s;
endpackage : rps_pkg
`default_nettype wire

// ==== dv/rps_host_model.sv ====
/* Host model: drives the toggle pin and the external reset pin.
   Assumes the bench supplies the clock and the requests. */
`default_nettype none
module rps_host_model (
    input wire logic mclk,
    input wire logic go,
    input wire logic [11:0] high_len,
    input wire logic hold_rst,
    output logic power_toggle,
    output logic ext_reset_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [11:0] cnt_q = 12'h000;
    initial power_toggle = 1'b0;
    // Low-high-low pulse; the bench picks the width to probe the filter
    always @(posedge mclk) begin
        if (go && cnt_q == 12'h000) begin
            power_toggle <= 1'b1;
            cnt_q <= high_len;
        end else if (cnt_q > 12'h001) begin
            cnt_q <= cnt_q - 12'h001;
        end else if (cnt_q == 12'h001) begin
            power_toggle <= 1'b0;
            cnt_q <= 12'h000;
        end
    end
    // Reset pin is a plain level from the bench
    assign ext_reset_n = !hold_rst;
endmodule : rps_host_model
`default_nettype wire

// ==== dv/test_rps_sequencer.sv ====
/* Bench for the power-state sequencer, one task per scenario.
   Assumes the host model is compiled before it. */
`default_nettype none
module test_receiver_power_state_sequencer;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk, rst, go, hold_rst, power_toggle, ext_reset_n;
    logic rtc_running, eeprom_present, reload_done, serial_oe_n, wakeup;
    logic data_ram_clear, reload_req, aiding_valid, orbit_store_en;
    logic patch_valid;
    logic [11:0] high_len;
    logic [15:0] pins_func, pins_out;
    logic [7:0] patch_rd_data;
    logic [14:0] patch_rd_addr;
    rps_pkg::rps_patch_wr_s patch_wr;
    rps_pkg::rps_state_e state;
    rps_pkg::rps_power_s power;
    int n_mismatch = 0;
    int n_checks = 0;
    rps_host_model host (.mclk, .go, .high_len, .hold_rst, .power_toggle,
        .ext_reset_n);
    rps_sequencer dut (.mclk, .rst, .power_toggle, .ext_reset_n,
        .rtc_running, .eeprom_present, .patch_wr, .reload_done, .pins_func,
        .pins_out, .serial_oe_n, .state, .power, .wakeup, .data_ram_clear,
        .reload_req, .aiding_valid, .orbit_store_en, .patch_valid,
        .patch_rd_data, .patch_rd_addr);
    // 20 MHz clock
    initial begin
        mclk = 1'b0;
        forever #25 mclk = ~mclk;
    end
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : results
    task automatic chk(input string what, input logic [15:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, seen);
        end
    endtask : chk
    // Bounded wait; a hang ends the run
    task automatic wait_st(input rps_pkg::rps_state_e s, input int lim);
        for (int i = 0; i < lim && state !== s; i++) begin
            @(posedge mclk);
            #1;
        end
        chk("state", state, s);
        if (state !== s) results();
    endtask : wait_st
    task automatic pulse(input logic [11:0] len);
        @(posedge mclk);
        high_len <= len;
        go <= 1'b1;
        @(posedge mclk);
        go <= 1'b0;
        repeat (len + 2) @(posedge mclk);
    endtask : pulse
    task automatic t_boot;
        #1;
        chk("state", state, rps_pkg::RPS_RESET);
        chk("clear", data_ram_clear, 1'b1);
        @(posedge mclk);
        rtc_running <= 1'b1;
        wait_st(rps_pkg::RPS_HIBER, 8);
        chk("power", power, 6'h3C);
        chk("orbit", orbit_store_en, 1'b1);
        pulse(12'd1700);
        // An accepted pulse would show one edge after the stages agree
        repeat (3) @(posedge mclk);
        #1;
        wait_st(rps_pkg::RPS_HIBER, 1);
        $display("boot and short pulse done");
    endtask : t_boot
    task automatic t_wake;
        @(posedge mclk);
        pins_func <= 16'hA5C3;
        pulse(12'd2000);
        wait_st(rps_pkg::RPS_FULL, 8);
        chk("wakeup", wakeup, 1'b1);
        chk("oe_n", serial_oe_n, 1'b0);
        chk("power", power, 6'h3F);
        chk("reload", reload_req, 1'b1);
        // Aiding flag and pins are registered from the full-on state
        @(posedge mclk);
        #1;
        chk("aiding", aiding_valid, 1'b1);
        chk("pins", pins_out, 16'hA5C3);
        @(posedge mclk);
        reload_done <= 1'b1;
        patch_wr <= '{1'b1, 15'h5FFF, 8'h5A};
        @(posedge mclk);
        reload_done <= 1'b0;
        patch_wr.valid <= 1'b0;
        patch_rd_addr <= 15'h5FFF;
        repeat (2) @(posedge mclk);
        #1;
        chk("reload", reload_req, 1'b0);
        chk("patch", patch_valid, 1'b1);
        chk("rd", patch_rd_data, 8'h5A);
        $display("wake done");
    endtask : t_wake
    task automatic t_sleep;
        pulse(12'd2000);
        wait_st(rps_pkg::RPS_HIBER, 8);
        @(posedge mclk);
        pins_func <= 16'h0F0F;
        repeat (3) @(posedge mclk);
        #1;
        chk("pins", pins_out, 16'hA5C3);
        chk("oe_n", serial_oe_n, 1'b1);
        chk("power", power, 6'h3C);
        pulse(12'd2000);
        wait_st(rps_pkg::RPS_FULL, 8);
        chk("reload", reload_req, 1'b0);
        $display("sleep done");
    endtask : t_sleep
    task automatic t_ext_reset;
        @(posedge mclk);
        hold_rst <= 1'b1;
        wait_st(rps_pkg::RPS_RESET, 8);
        chk("clear", data_ram_clear, 1'b1);
        // Patch flag drops one edge after the reset state is entered
        @(posedge mclk);
        #1;
        chk("patch", patch_valid, 1'b0);
        chk("aiding", aiding_valid, 1'b1);
        @(posedge mclk);
        hold_rst <= 1'b0;
        wait_st(rps_pkg::RPS_HIBER, 12);
        pulse(12'd2000);
        wait_st(rps_pkg::RPS_FULL, 8);
        chk("reload", reload_req, 1'b1);
        $display("ext reset done");
    endtask : t_ext_reset
    // Without an eeprom nothing is reloaded and orbit storage is off
    task automatic t_no_eeprom;
        @(posedge mclk);
        eeprom_present <= 1'b0;
        hold_rst <= 1'b1;
        wait_st(rps_pkg::RPS_RESET, 8);
        chk("orbit", orbit_store_en, 1'b0);
        chk("reload", reload_req, 1'b0);
        @(posedge mclk);
        hold_rst <= 1'b0;
        wait_st(rps_pkg::RPS_HIBER, 12);
        pulse(12'd2000);
        wait_st(rps_pkg::RPS_FULL, 8);
        chk("reload", reload_req, 1'b0);
        $display("no eeprom done");
    endtask : t_no_eeprom
    // Main sequence; the strap drops only in the last scenario
    initial begin
        rst = 1'b1;
        go = 1'b0;
        hold_rst = 1'b0;
        high_len = 12'h000;
        rtc_running = 1'b0;
        eeprom_present = 1'b1;
        reload_done = 1'b0;
        pins_func = 16'h0000;
        patch_rd_addr = 15'h0000;
        patch_wr = '0;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        t_boot();
        t_wake();
        t_sleep();
        t_ext_reset();
        t_no_eeprom();
        results();
    end
endmodule : test_receiver_power_state_sequencer
`default_nettype wire
